// >>> logic/pcpm_defs.svh
// Constants for the port configuration preload loader.
// Summary of operation
// R1: Power-management word bit 0 becomes the skip-state-reset flag, 44h bit 3.
// R2: Power-management word bits 3:1 become auxiliary current, 40h bits 24:22.
// R3: Power-management bit 4 (40h bit 25) always reads 1: D1 supported.
// R4: Power-management bit 5 (40h bit 26) always reads 1: D2 supported.
// R5: Power-management bits 7:6 become PME support from D2/D1, 40h bits 29:28.
// R6: Power-management upper byte becomes the read-only data byte, 44h bits 31:24.
// R7: Without preload, power-management low byte is FFh and data byte 00h.
// R8: Link-layer control words 58h to 5Eh load offset 340h bits 15:0, default 0000h.
// R9: Slot word bit 1 becomes connector reference clock flag, D0h bit 28.
// R10: Slot word bit 2 becomes device-specific initialization flag, 40h bit 21.
// R11: Slot word bit 3 becomes low-priority VC count, 144h bit 4.
// R12: Slot word bits 6:4 become logical port number, CCh bits 26:24.
// R13: Slot word bits 15:9 become VC0 traffic-class map; upper byte defaults FEh.
// R14: Ports 1 and 2: slot word bit 0 becomes slot implemented, C0h bit 24.
// R15: Slot low byte defaults 02h, 12h, 22h for ports 0, 1, 2.
// R16: All fields are loaded before the upstream host may access configuration.
`ifndef PCPM_DEFS_SVH
`define PCPM_DEFS_SVH

// ****************************************
// Store word layout
// ****************************************
`define PCPM_FIRST_WORD   8'h50
`define PCPM_NUM_WORDS    4'hB
`define PCPM_LAST_IDX     4'hA
`define PCPM_LLC_IDX      4'h4
`define PCPM_SLOT_IDX     4'h8
`define PCPM_NUM_PM       4
`define PCPM_NUM_LLC      4
`define PCPM_NUM_SLOT     3
`define PCPM_WAIT_LIMIT   255

// ****************************************
// Field positions
// ****************************************
`define PCPM_PM_SKIP      0
`define PCPM_PM_AUX       1
`define PCPM_PM_D1        4
`define PCPM_PM_D2        5
`define PCPM_PM_PME       6
`define PCPM_PM_DATA      8
`define PCPM_SL_IMPL      0
`define PCPM_SL_CLK       1
`define PCPM_SL_DSI       2
`define PCPM_SL_LOW_PRIORITY_VC_COUNT      3
`define PCPM_SL_PNUM      4
`define PCPM_SL_TC        9

// ****************************************
// Reset values
// ****************************************
`define PCPM_PM_DFLT      16'h00FF
`define PCPM_PM_FORCE     16'h0030
`define PCPM_LLC_DFLT     16'h0000
`define PCPM_SLOT0_DFLT   16'hFE02
`define PCPM_SLOT1_DFLT   16'hFE12
`define PCPM_SLOT2_DFLT   16'hFE22

`endif

// >>> logic/pcpm_pkg.sv
// Types shared by the port configuration preload loader.
package pcpm_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_WAIT = 2'b10,
		ST_DONE = 2'b11
	} pcpm_state_t;
	typedef logic [15:0] pcpm_word_t;
endpackage

// >>> logic/pcpm_wait_timer.sv
// Timeout counter that bounds the wait for one store word.
`timescale 1ns/1ps
`include "pcpm_defs.svh"
module pcpm_wait_timer #(
	parameter int LIMIT = `PCPM_WAIT_LIMIT
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      expired
);
	logic [7:0] cnt_r;

	// Counter restarts whenever a wait ends, so every word gets the full budget.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= 8'h00;
			expired <= 1'b0;
		end else if (!run) begin
			cnt_r   <= 8'h00;
			expired <= 1'b0;
		end else begin
			cnt_r   <= cnt_r + 8'h01;
			expired <= (cnt_r == 8'(LIMIT - 1));
		end
	end
endmodule // pcpm_wait_timer

// >>> logic/pcpm_loader.sv
// Loader that copies store preload words into per-port configuration fields.
`timescale 1ns/1ps
`include "pcpm_defs.svh"
module pcpm_loader #(
	parameter int WAIT_LIMIT = `PCPM_WAIT_LIMIT
) (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               store_present,
	output logic                    rd_req,
	output logic [7:0]              rd_addr,
	input  wire pcpm_pkg::pcpm_word_t rd_data,
	input  wire logic               rd_valid,
	output logic                    cfg_access_en,
	output logic [3:0]              pm_skip_reset,
	output logic [11:0]             pm_aux_current,
	output logic [3:0]              pm_d1_sup,
	output logic [3:0]              pm_d2_sup,
	output logic [7:0]              pm_pme_sup,
	output logic [31:0]             pm_data,
	output logic [63:0]             link_layer_ctrl_word,
	output logic [1:0]              slot_impl,
	output logic [2:0]              slot_clk_cfg,
	output logic [2:0]              dev_init_req,
	output logic [2:0]              low_priority_vc_count,
	output logic [8:0]              port_number,
	output logic [20:0]             tc_vc_map
);
	import pcpm_pkg::*;

	// ****************************************
	// Sequencer
	// ****************************************
	pcpm_state_t state_r;
	pcpm_state_t state_nxt;
	logic [3:0]  idx_r;
	logic        expired;
	logic        capture;
	logic        word_end;
	pcpm_word_t  pm_word_r   [`PCPM_NUM_PM];
	pcpm_word_t  llc_word_r  [`PCPM_NUM_LLC];
	pcpm_word_t  slot_word_r [`PCPM_NUM_SLOT];

	assign capture  = (state_r == ST_WAIT) && rd_valid;
	assign word_end = (state_r == ST_WAIT) && (rd_valid || expired);

	// A missing store leaves every field at its default and opens access at once.
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				state_nxt = store_present ? ST_REQ : ST_DONE; // [R7] [R15]
			end
			ST_REQ: begin
				state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				if (word_end) begin
					state_nxt = (idx_r == `PCPM_LAST_IDX) ? ST_DONE : ST_REQ;
				end
			end
			ST_DONE: begin
				state_nxt = ST_DONE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Word index advances after every word but the last, whether read or timed out.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx_r <= 4'h0;
		end else if (word_end && (idx_r != `PCPM_LAST_IDX)) begin
			idx_r <= idx_r + 4'h1;
		end
	end

	// Store words sit two address units apart, so the index is doubled.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_req  <= 1'b0;
			rd_addr <= `PCPM_FIRST_WORD;
		end else begin
			rd_req <= (state_r == ST_REQ);
			if (state_r == ST_REQ) begin
				rd_addr <= `PCPM_FIRST_WORD + {3'b000, idx_r, 1'b0};
			end
		end
	end

	// Host access opens only once the sequencer has reached ST_DONE.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_access_en <= 1'b0;
		end else begin
			cfg_access_en <= (state_r == ST_DONE); // [R16]
		end
	end

	pcpm_wait_timer #(
		.LIMIT   (WAIT_LIMIT)
	) u_timer (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (state_r == ST_WAIT),
		.expired (expired)
	);

	// ****************************************
	// Word storage and field mapping
	// ****************************************
	genvar p;
	generate
		for (p = 0; p < `PCPM_NUM_PM; p++) begin : g_pm
			// Capability bits for D1 and D2 are forced so the store cannot clear them.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pm_word_r[p] <= `PCPM_PM_DFLT; // [R7]
				end else if (capture && (idx_r == 4'(p))) begin
					pm_word_r[p] <= rd_data | `PCPM_PM_FORCE; // [R3] [R4]
				end
			end
			assign pm_skip_reset[p]        = pm_word_r[p][`PCPM_PM_SKIP];        // [R1]
			assign pm_aux_current[3*p +: 3] = pm_word_r[p][`PCPM_PM_AUX +: 3];   // [R2]
			assign pm_d1_sup[p]            = pm_word_r[p][`PCPM_PM_D1];          // [R3]
			assign pm_d2_sup[p]            = pm_word_r[p][`PCPM_PM_D2];          // [R4]
			assign pm_pme_sup[2*p +: 2]    = pm_word_r[p][`PCPM_PM_PME +: 2];    // [R5]
			assign pm_data[8*p +: 8]       = pm_word_r[p][`PCPM_PM_DATA +: 8];   // [R6]
		end
		for (p = 0; p < `PCPM_NUM_LLC; p++) begin : g_llc
			// Link-layer control word is taken whole.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					llc_word_r[p] <= `PCPM_LLC_DFLT; // [R8]
				end else if (capture && (idx_r == `PCPM_LLC_IDX + 4'(p))) begin
					llc_word_r[p] <= rd_data; // [R8]
				end
			end
			assign link_layer_ctrl_word[16*p +: 16] = llc_word_r[p];
		end
		for (p = 0; p < `PCPM_NUM_SLOT; p++) begin : g_slot
			// Each port resets to its own default so port numbers differ without a store.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					if (p == 0) begin
						slot_word_r[p] <= `PCPM_SLOT0_DFLT; // [R15]
					end else if (p == 1) begin
						slot_word_r[p] <= `PCPM_SLOT1_DFLT; // [R15]
					end else begin
						slot_word_r[p] <= `PCPM_SLOT2_DFLT; // [R15] [R13]
					end
				end else if (capture && (idx_r == `PCPM_SLOT_IDX + 4'(p))) begin
					slot_word_r[p] <= rd_data;
				end
			end
			assign slot_clk_cfg[p]          = slot_word_r[p][`PCPM_SL_CLK];        // [R9]
			assign dev_init_req[p]          = slot_word_r[p][`PCPM_SL_DSI];        // [R10]
			assign low_priority_vc_count[p] = slot_word_r[p][`PCPM_SL_LOW_PRIORITY_VC_COUNT];       // [R11]
			assign port_number[3*p +: 3]    = slot_word_r[p][`PCPM_SL_PNUM +: 3];  // [R12]
			assign tc_vc_map[7*p +: 7]      = slot_word_r[p][`PCPM_SL_TC +: 7];    // [R13]
			if (p > 0) begin : g_impl
				// Port 0 is the upstream port and has no slot bit.
				assign slot_impl[p-1] = slot_word_r[p][`PCPM_SL_IMPL]; // [R14]
			end
		end
	endgenerate

	// ****************************************
	// Checks
	// ****************************************
	chk_access_after_done: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
		cfg_access_en |-> (state_r == ST_DONE) && $past(state_r == ST_DONE))
		else $error("host access opened before loading finished");

	chk_d1_always_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
		pm_d1_sup == 4'hF)
		else $error("D1 support bit not reading as one");

	chk_d2_always_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
		pm_d2_sup == 4'hF)
		else $error("D2 support bit not reading as one");

	chk_skip_bit_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
		(capture && (idx_r < 4'h4)) |=> pm_skip_reset[$past(idx_r[1:0])] == $past(rd_data[0]))
		else $error("skip-state-reset flag not copied");

	chk_aux_data_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2] [R6]
		(capture && (idx_r == 4'h2)) |=> (pm_aux_current[8:6] == $past(rd_data[3:1]))
			&& (pm_data[23:16] == $past(rd_data[15:8])))
		else $error("port 2 power-management fields not copied");

	chk_llc_word_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
		(capture && (idx_r == 4'h5)) |=> link_layer_ctrl_word[31:16] == $past(rd_data))
		else $error("link-layer control word not copied");

	chk_slot_fields_copy: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12] [R13]
		(capture && (idx_r == 4'h9)) |=> (port_number[5:3] == $past(rd_data[6:4]))
			&& (tc_vc_map[13:7] == $past(rd_data[15:9])) && (slot_impl[0] == $past(rd_data[0])))
		else $error("port 1 slot fields not copied");

	chk_req_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_req |-> (state_r == ST_WAIT) ##1 !rd_req)
		else $error("store read request longer than one cycle");

	chk_absent_skips_load: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7] [R15]
		((state_r == ST_IDLE) && !store_present) |=> ##1 cfg_access_en && (pm_data == 32'h0000_0000)
			&& (port_number == 9'h088))
		else $error("defaults not kept when no store present");
endmodule // pcpm_loader

// >>> verification/pcpm_store_model.sv
// Behavioural model of the preload word store that answers the loader.
`timescale 1ns/1ps
module pcpm_store_model (
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          rd_req,
	input  wire logic [7:0]    rd_addr,
	input  wire logic [175:0]  words,
	input  wire logic [3:0]    lat,
	input  wire logic [3:0]    mute_idx,
	output logic      [15:0]   rd_data,
	output logic               rd_valid
);
	logic [3:0] idx;
	logic [3:0] idx_r;
	logic [3:0] cnt_r;
	logic       pend_r;
	// Word index of the current request address.
	assign idx = 4'((rd_addr - 8'h50) >> 1);
	// A zero latency answers in the cycle after the request; a muted word is never answered.
	// Between answers the data toggles, so a loader sampling it outside valid picks up a wrong word.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data  <= 16'h0000;
			pend_r   <= 1'b0;
			cnt_r    <= 4'h0;
			idx_r    <= 4'h0;
		end else if (rd_req) begin
			idx_r    <= idx;
			cnt_r    <= lat - 4'h1;
			pend_r   <= (lat != 4'h0) && (idx != mute_idx);
			rd_valid <= (lat == 4'h0) && (idx != mute_idx);
			rd_data  <= (lat == 4'h0) ? words[16*idx +: 16] : ~rd_data;
		end else if (pend_r && cnt_r != 4'h0) begin
			cnt_r    <= cnt_r - 4'h1;
			rd_valid <= 1'b0;
			rd_data  <= ~rd_data;
		end else if (pend_r) begin
			pend_r   <= 1'b0;
			rd_valid <= 1'b1;
			rd_data  <= words[16*idx_r +: 16];
		end else begin
			rd_valid <= 1'b0;
			rd_data  <= ~rd_data;
		end
	end
endmodule // pcpm_store_model

// >>> verification/tb_top.sv
// Self-checking testbench of the port configuration preload loader.
`timescale 1ns/1ps
module tb_top;
	import pcpm_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam logic [175:0] DFLT = {16'hFE22, 16'hFE12, 16'hFE02, 64'h0000_0000_0000_0000, {4{16'h00FF}}};
	localparam logic [175:0] PAT  = 176'h0F7B_5A57_A5F9_7FFE_8001_FEDC_1234_3C39_C3F6_5A0E_A5C3;
	logic         ref_clk, rst_n, store_present, rd_req, rd_valid, cfg_access_en;
	logic [7:0]   rd_addr, pm_pme_sup;
	pcpm_word_t   rd_data;
	logic [3:0]   pm_skip_reset, pm_d1_sup, pm_d2_sup, lat, mute_idx;
	logic [11:0]  pm_aux_current;
	logic [31:0]  pm_data;
	logic [63:0]  link_layer_ctrl_word;
	logic [1:0]   slot_impl;
	logic [2:0]   slot_clk_cfg, dev_init_req, low_priority_vc_count;
	logic [8:0]   port_number;
	logic [20:0]  tc_vc_map;
	logic [175:0] words;
	int           bad_count, compares, n_req;
	pcpm_loader #(.WAIT_LIMIT(8)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .store_present(store_present),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .cfg_access_en(cfg_access_en),
		.pm_skip_reset(pm_skip_reset), .pm_aux_current(pm_aux_current), .pm_d1_sup(pm_d1_sup), .pm_d2_sup(pm_d2_sup),
		.pm_pme_sup(pm_pme_sup), .pm_data(pm_data), .link_layer_ctrl_word(link_layer_ctrl_word),
		.slot_impl(slot_impl), .slot_clk_cfg(slot_clk_cfg), .dev_init_req(dev_init_req),
		.low_priority_vc_count(low_priority_vc_count), .port_number(port_number), .tc_vc_map(tc_vc_map));
	pcpm_store_model i_store (.ref_clk(ref_clk), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr),
		.words(words), .lat(lat), .mute_idx(mute_idx), .rd_data(rd_data), .rd_valid(rd_valid));
	// The 40 MHz clock toggles every half period.
	initial ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Every request must walk the addresses in order while the host is still locked out.
	always @(posedge ref_clk) begin
		if (rst_n && rd_req) begin
			check({cfg_access_en, rd_addr}, {1'b0, 8'(8'h50 + 2*n_req)}, "request order or early access");
			n_req++;
		end
	end
	task automatic do_reset();
		@(posedge ref_clk);
		rst_n <= 1'b0;
		n_req = 0;
		repeat (20) @(posedge ref_clk);
		check(cfg_access_en, 1'b0, "host access open in reset");
		rst_n <= 1'b1;
	endtask
	task automatic wait_done(input int reqs);
		for (int i = 0; i < 600 && cfg_access_en !== 1'b1; i++) @(posedge ref_clk);
		check(cfg_access_en, 1'b1, "load never completed");
		check(n_req, reqs, "wrong number of word reads");
	endtask
	// Expected field outputs are sliced out of the eleven store words.
	task automatic check_fields(input logic [175:0] w);
		logic [15:0] pm, sl;
		logic [3:0]  sk;
		logic [11:0] ax;
		logic [7:0]  pe;
		logic [31:0] dt;
		logic [2:0]  ck, ds, lp;
		logic [8:0]  pn;
		logic [20:0] tc;
		logic [1:0]  im;
		for (int p = 0; p < 4; p++) begin
			pm = w[16*p +: 16];
			sk[p] = pm[0];
			ax[3*p +: 3] = pm[3:1];
			pe[2*p +: 2] = pm[7:6];
			dt[8*p +: 8] = pm[15:8];
		end
		for (int p = 0; p < 3; p++) begin
			sl = w[16*(8+p) +: 16];
			ck[p] = sl[1];
			ds[p] = sl[2];
			lp[p] = sl[3];
			pn[3*p +: 3] = sl[6:4];
			tc[7*p +: 7] = sl[15:9];
			if (p > 0) im[p-1] = sl[0];
		end
		check(pm_skip_reset, sk, "skip reset flags");
		check(pm_aux_current, ax, "aux current");
		check({pm_d1_sup, pm_d2_sup}, 8'hFF, "D1 D2 support");
		check(pm_pme_sup, pe, "PME support");
		check(pm_data, dt, "power data byte");
		check(link_layer_ctrl_word, w[127:64], "link layer control");
		check(slot_clk_cfg, ck, "slot clock");
		check(dev_init_req, ds, "device init");
		check(low_priority_vc_count, lp, "low priority VC");
		check(port_number, pn, "port number");
		check(tc_vc_map, tc, "TC VC map");
		check(slot_impl, im, "slot implemented");
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_absent();
		@(posedge ref_clk);
		store_present <= 1'b0;
		do_reset();
		wait_done(0);
		check_fields(DFLT);
		$display("test_absent done");
	endtask
	task automatic test_load();
		@(posedge ref_clk);
		store_present <= 1'b1;
		words <= PAT;
		lat <= 4'h0;
		mute_idx <= 4'hF;
		do_reset();
		wait_done(11);
		check_fields(PAT);
		$display("test_load done");
	endtask
	// A silent word must time out and leave its fields at the default while slow words still load.
	task automatic test_skip(input logic [3:0] m, input logic [3:0] l);
		logic [175:0] exp;
		exp = PAT;
		exp[16*m +: 16] = DFLT[16*m +: 16];
		@(posedge ref_clk);
		store_present <= 1'b1;
		words <= PAT;
		lat <= l;
		mute_idx <= m;
		do_reset();
		wait_done(11);
		check_fields(exp);
		$display("test_skip done");
	endtask
	initial begin
		rst_n = 1'b0;
		store_present = 1'b0;
		words = '0;
		lat = 4'h0;
		mute_idx = 4'hF;
		test_absent();
		test_load();
		test_skip(4'h9, 4'h3);
		test_skip(4'h2, 4'h1);
		stop_test();
	end
	// A hang is cut short well after the four tests should have finished.
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		stop_test();
	end
endmodule // tb_top
